/* File: verilog/arpt_pkg.sv */
/*
 holds the register map, field positions, reset values and shared types of the
 auto-reload pwm timer. assumes a classic wishbone slave with 32-bit data.
*/
package arpt_pkg;

	localparam logic [7:0] ARPT_CSR_OFF      = 8'h00;
	localparam logic [7:0] ARPT_CNT_OFF      = 8'h04;
	localparam logic [7:0] ARPT_RLD_OFF      = 8'h08;
	localparam logic [7:0] ARPT_DUTY0_OFF    = 8'h0C;
	localparam logic [7:0] ARPT_DUTY1_OFF    = 8'h10;
	localparam logic [7:0] ARPT_PWMCTL_OFF   = 8'h14;
	localparam logic [7:0] ARPT_CAPCSR_OFF   = 8'h18;
	localparam logic [7:0] ARPT_CAPV0_OFF    = 8'h1C;
	localparam logic [7:0] ARPT_CAPV1_OFF    = 8'h20;
	localparam logic [7:0] ARPT_MODE_OFF     = 8'h24;

	localparam int CSR_EXT_BIT  = 7;
	localparam int CSR_PSC_LSB  = 4;
	localparam int CSR_RUN_BIT  = 3;
	localparam int CSR_FRL_BIT  = 2;
	localparam int CSR_OIE_BIT  = 1;
	localparam int CSR_OVF_BIT  = 0;
	localparam int PWM_OE_LSB   = 4;
	localparam int PWM_POL_LSB  = 0;
	localparam int CAP_EDG_LSB  = 4;
	localparam int CAP_IE_LSB   = 2;
	localparam int CAP_FLG_LSB  = 0;

	localparam logic [7:0] ARPT_RST_BYTE = 8'h00;
	localparam logic [6:0] ARPT_PSC_ZERO = 7'h00;
	localparam logic [7:0] ARPT_CNT_MAX  = 8'hFF;
	localparam int         ARPT_CHANS    = 2;

	typedef struct packed {
		logic       ext_sel;
		logic [2:0] psc_sel;
		logic       run;
		logic       overflow_irq_enable;
		logic       ovf;
	} arpt_csr_t;

	typedef struct packed {
		logic [1:0] oe;
		logic [1:0] pol;
	} arpt_pwmctl_t;

	typedef struct packed {
		logic [1:0] edge_rise;
		logic [1:0] ie;
		logic [1:0] flag;
	} arpt_capcsr_t;

	typedef enum logic [0:0] {
		ARPT_BUS_IDLE = 1'b0,
		ARPT_BUS_ACK  = 1'b1
	} arpt_bus_t;

endpackage : arpt_pkg

/* File: verilog/arpt_timer.sv */
/*
 8-bit auto-reload timer with 7-bit prescaler, two pwm channels and two
 capture channels, registers on a classic wishbone slave.
 assumes event clock, capture pins and halt come from outside this clock domain.
*/
`timescale 1ns/10ps

// Summary of operation
// R1: prescale divides input by 2^select, eight taps of a 7-bit prescaler.
// R2: control bit 7 selects cpu clock (0) or external event clock (1).
// R3: run bit 3 low freezes counter and prescaler; high counts.
// R4: reset clears counter, prescaler, and selects cpu clock.
// R5: counter write or forced reload loads counter and clears prescaler.
// R6: force reload bit 2 reads zero; writing one loads reload value.
// R7: hidden compare per channel reloads from duty register on each overflow.
// R8: counter register reads live count; writes take effect immediately.
// R9: output enable drives the pwm pin push-pull.
// R10: pwm period is counter clock divided by 256 minus reload.
// R11: overflow sets level by polarity; compare match restores level.
// R12: software keeps compare above reload for a visible waveform.
// R13: pwm stops while halted.
// R14: overflow sets flag; interrupt when overflow interrupt enable set.
// R15: overflow flag marks FFh to reload; reading control register clears it.
// R16: event mode sets overflow after (256 minus reload) times 2^select external events.
// R17: halted with external clock, control freezes, counter counts, overflow wakes.
// R18: selected capture edge latches counter and sets capture flag.
// R19: capture register blocked until capture status read clears flag.
// R20: capture interrupt pends while flag and enable are set.
// R21: halted, capture latching stops; capture edges still may wake.
// R22: capture events are sampled on counter clock ticks.
// R23: counter increments per prescaler tick, reloads on overflow, prescaler untouched.
// R24: edge select zero picks falling, one picks rising.
// R25: duty FFh holds output at 0, duty 00h holds it at 1.
// R26: event clock and capture inputs are synchronised and edge-detected to single-cycle pulses.
module arpt_timer
	import arpt_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        halt_i,
	input  wire logic        event_clock_input_i,
	input  wire logic [1:0]  capture_input_pin_i,
	output logic      [1:0]  pwm_out_pin_o,
	output logic      [1:0]  pwm_out_pin_oe_o,
	output logic             ovf_irq_o,
	output logic      [1:0]  cap_irq_o,
	output logic             wake_o
);

	arpt_csr_t    csr_reg;
	arpt_pwmctl_t pwmctl_reg;
	arpt_capcsr_t capcsr_reg;
	arpt_bus_t    bus_reg;
	logic [7:0]   cnt_reg;
	logic [6:0]   psc_reg;
	logic [7:0]   rld_reg;
	logic [7:0]   duty_reg [ARPT_CHANS];
	logic [7:0]   cmp_reg  [ARPT_CHANS];
	logic [7:0]   capv_reg [ARPT_CHANS];
	logic [1:0]   pwm_lvl_reg;
	logic [2:0]   ext_sync_reg;
	logic [1:0]   halt_sync_reg;
	logic [2:0]   cap_sync_reg [ARPT_CHANS];
	logic [1:0]   cap_pend_reg;

	logic         wr_stb;
	logic         rd_stb;
	logic         in_tick;
	logic [6:0]   psc_next;
	logic         cnt_tick;
	logic         ovf_evt;
	logic         cnt_wr;
	logic         frl_wr;
	logic         halted;
	logic [1:0]   cap_edge;
	logic [31:0]  rd_data;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr == off);
	endfunction : hit

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && (bus_reg == ARPT_BUS_IDLE)
	                && wb_sel_i[0];
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && (bus_reg == ARPT_BUS_IDLE);
	assign halted = halt_sync_reg[1];
	// control registers freeze while halted
	assign cnt_wr = wr_stb && hit(wb_adr_i, ARPT_CNT_OFF) && !halted; // R17
	assign frl_wr = wr_stb && hit(wb_adr_i, ARPT_CSR_OFF) && wb_dat_i[CSR_FRL_BIT]
	                && !halted;

	// synchronisers: stage 0 is read only by stage 1
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			ext_sync_reg  <= 3'h0;
			halt_sync_reg <= 2'h0;
		end
		else
		begin
			ext_sync_reg  <= {ext_sync_reg[1:0], event_clock_input_i}; // R26
			halt_sync_reg <= {halt_sync_reg[0], halt_i};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < ARPT_CHANS; gi++)
		begin : g_cap_sync
			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					cap_sync_reg[gi] <= 3'h0;
				else
					cap_sync_reg[gi] <= {cap_sync_reg[gi][1:0], capture_input_pin_i[gi]};
			end
			// R24
			assign cap_edge[gi] = capcsr_reg.edge_rise[gi]
			                      ? (cap_sync_reg[gi][1] && !cap_sync_reg[gi][2])
			                      : (!cap_sync_reg[gi][1] && cap_sync_reg[gi][2]);
		end
	endgenerate

	// cpu clock stops in halt; only the external event path keeps counting
	always_comb
	begin
		if (csr_reg.ext_sel) // R2
			in_tick = ext_sync_reg[1] && !ext_sync_reg[2]; // R26
		else
			in_tick = !halted; // R13
		in_tick = in_tick && csr_reg.run; // R3
	end

	assign psc_next = psc_reg + 7'h01;
	// tap n fires when the low n prescaler bits wrap to zero
	always_comb
	begin
		if (csr_reg.psc_sel == 3'h0)
			cnt_tick = in_tick; // R1
		else
			cnt_tick = in_tick && ((psc_next & ((7'h01 << csr_reg.psc_sel) - 7'h01))
			           == ARPT_PSC_ZERO); // R1
	end
	assign ovf_evt = cnt_tick && (cnt_reg == ARPT_CNT_MAX) && !cnt_wr && !frl_wr;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			psc_reg <= ARPT_PSC_ZERO; // R4
		else if (cnt_wr || frl_wr)
			psc_reg <= ARPT_PSC_ZERO; // R5
		else if (in_tick)
			psc_reg <= psc_next; // R23
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			cnt_reg <= ARPT_RST_BYTE; // R4
		else if (cnt_wr)
			cnt_reg <= wb_dat_i[7:0]; // R8
		else if (frl_wr)
			cnt_reg <= rld_reg; // R6
		else if (ovf_evt)
			cnt_reg <= rld_reg; // R23
		else if (cnt_tick)
			cnt_reg <= cnt_reg + 8'h01; // R23
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			csr_reg <= '0; // R4
		else
		begin
			if (wr_stb && hit(wb_adr_i, ARPT_CSR_OFF) && !halted)
			begin
				csr_reg.ext_sel <= wb_dat_i[CSR_EXT_BIT];
				csr_reg.psc_sel <= wb_dat_i[CSR_PSC_LSB +: 3];
				csr_reg.run     <= wb_dat_i[CSR_RUN_BIT];
				csr_reg.overflow_irq_enable     <= wb_dat_i[CSR_OIE_BIT];
			end
			// set wins over the read clear
			if (ovf_evt)
				csr_reg.ovf <= 1'b1; // R14 R16
			else if (rd_stb && hit(wb_adr_i, ARPT_CSR_OFF))
				csr_reg.ovf <= 1'b0; // R15
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			rld_reg    <= ARPT_RST_BYTE;
			pwmctl_reg <= '0;
			duty_reg   <= '{default: ARPT_RST_BYTE};
			capcsr_reg.edge_rise <= 2'h0;
			capcsr_reg.ie        <= 2'h0;
		end
		else if (wr_stb && !halted)
		begin
			if (hit(wb_adr_i, ARPT_RLD_OFF))
				rld_reg <= wb_dat_i[7:0];
			if (hit(wb_adr_i, ARPT_DUTY0_OFF))
				duty_reg[0] <= wb_dat_i[7:0];
			if (hit(wb_adr_i, ARPT_DUTY1_OFF))
				duty_reg[1] <= wb_dat_i[7:0];
			if (hit(wb_adr_i, ARPT_PWMCTL_OFF))
			begin
				pwmctl_reg.oe  <= wb_dat_i[PWM_OE_LSB +: 2];
				pwmctl_reg.pol <= wb_dat_i[PWM_POL_LSB +: 2];
			end
			if (hit(wb_adr_i, ARPT_CAPCSR_OFF))
			begin
				capcsr_reg.edge_rise <= wb_dat_i[CAP_EDG_LSB +: 2];
				capcsr_reg.ie        <= wb_dat_i[CAP_IE_LSB +: 2];
			end
		end
	end

	generate
		for (gi = 0; gi < ARPT_CHANS; gi++)
		begin : g_chan
			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					cmp_reg[gi] <= ARPT_RST_BYTE;
				else if (ovf_evt)
					cmp_reg[gi] <= duty_reg[gi]; // R7
			end

			// raw level is 1 after overflow unless a nonzero duty is FFh or equals reload, 0 after match; polarity applied at pin
			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					pwm_lvl_reg[gi] <= 1'b0;
				else if (halted)
					pwm_lvl_reg[gi] <= pwm_lvl_reg[gi]; // R13
				else if (ovf_evt)
					pwm_lvl_reg[gi] <= (duty_reg[gi] == 8'h00)
					                   || ((duty_reg[gi] != rld_reg)
					                   && (duty_reg[gi] != ARPT_CNT_MAX)); // R11 R10 R25
				else if (cnt_tick && !cnt_wr && !frl_wr
				         && (cnt_reg + 8'h01 == cmp_reg[gi]))
					pwm_lvl_reg[gi] <= 1'b0; // R11
			end

			// pending edge waits for the next counter tick
			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					cap_pend_reg[gi] <= 1'b0;
				else if (cnt_tick || halted)
					cap_pend_reg[gi] <= 1'b0; // R22
				else if (cap_edge[gi])
					cap_pend_reg[gi] <= 1'b1;
			end

			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					capv_reg[gi] <= ARPT_RST_BYTE;
				else if ((cap_edge[gi] || cap_pend_reg[gi]) && cnt_tick
				         && !capcsr_reg.flag[gi] && !halted)
					capv_reg[gi] <= cnt_reg; // R18 R19 R21
			end

			always_ff @(posedge core_clk_i)
			begin
				if (!rst_b_i)
					capcsr_reg.flag[gi] <= 1'b0;
				else if ((cap_edge[gi] || cap_pend_reg[gi]) && (cnt_tick || halted))
					capcsr_reg.flag[gi] <= 1'b1; // R18 R22
				else if (rd_stb && hit(wb_adr_i, ARPT_CAPCSR_OFF))
					capcsr_reg.flag[gi] <= 1'b0; // R19
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			pwm_out_pin_o    <= 2'h0;
			pwm_out_pin_oe_o <= 2'h0;
			ovf_irq_o        <= 1'b0;
			cap_irq_o        <= 2'h0;
			wake_o           <= 1'b0;
		end
		else
		begin
			// pin comes from a flop so a polarity or enable change cannot glitch it
			pwm_out_pin_o    <= (pwm_lvl_reg ^ pwmctl_reg.pol) & pwmctl_reg.oe; // R9 R11
			pwm_out_pin_oe_o <= pwmctl_reg.oe; // R9
			ovf_irq_o        <= csr_reg.ovf && csr_reg.overflow_irq_enable; // R14
			cap_irq_o        <= capcsr_reg.flag & capcsr_reg.ie; // R20
			wake_o           <= halted && ((csr_reg.ovf && csr_reg.overflow_irq_enable)
			                    || |(capcsr_reg.flag & capcsr_reg.ie)); // R17 R21
		end
	end

	always_comb
	begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			ARPT_CSR_OFF:    rd_data[7:0] = {csr_reg.ext_sel, csr_reg.psc_sel, csr_reg.run,
			                                 1'b0, csr_reg.overflow_irq_enable, csr_reg.ovf}; // R6
			ARPT_CNT_OFF:    rd_data[7:0] = cnt_reg; // R8
			ARPT_RLD_OFF:    rd_data[7:0] = rld_reg;
			ARPT_DUTY0_OFF:  rd_data[7:0] = duty_reg[0];
			ARPT_DUTY1_OFF:  rd_data[7:0] = duty_reg[1];
			ARPT_PWMCTL_OFF: rd_data[7:0] = {2'h0, pwmctl_reg.oe, 2'h0, pwmctl_reg.pol};
			ARPT_CAPCSR_OFF: rd_data[7:0] = {2'h0, capcsr_reg};
			ARPT_CAPV0_OFF:  rd_data[7:0] = capv_reg[0];
			ARPT_CAPV1_OFF:  rd_data[7:0] = capv_reg[1];
			ARPT_MODE_OFF:   rd_data[7:0] = {7'h00, halted};
			default:         rd_data = 32'h0000_0000;
		endcase
	end

	// one-cycle answer, then a forced idle cycle so a held strobe is not re-taken
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			bus_reg  <= ARPT_BUS_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			case (bus_reg)
				ARPT_BUS_IDLE:
				begin
					wb_ack_o <= wb_cyc_i && wb_stb_i;
					wb_dat_o <= rd_data;
					if (wb_cyc_i && wb_stb_i)
						bus_reg <= ARPT_BUS_ACK;
				end
				ARPT_BUS_ACK:
				begin
					wb_ack_o <= 1'b0;
					bus_reg  <= ARPT_BUS_IDLE;
				end
				default:
				begin
					wb_ack_o <= 1'b0;
					bus_reg  <= ARPT_BUS_IDLE;
				end
			endcase
		end
	end

	sequence s_top_tick;
		cnt_tick && (cnt_reg == ARPT_CNT_MAX) && !cnt_wr && !frl_wr;
	endsequence

	AST_RELOAD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R23
		s_top_tick |=> (cnt_reg == $past(rld_reg))) else $error("no reload on overflow");
	AST_OVF_SET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R14
		s_top_tick |=> csr_reg.ovf) else $error("overflow flag not set");
	AST_OVF_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R14
		(csr_reg.ovf && csr_reg.overflow_irq_enable) |=> ovf_irq_o) else $error("overflow irq missing");
	AST_STOP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R3
		(!csr_reg.run && !cnt_wr && !frl_wr) |=> $stable(cnt_reg) && $stable(psc_reg))
		else $error("counter moved while stopped");
	AST_PSC_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R5
		(cnt_wr || frl_wr) |=> (psc_reg == ARPT_PSC_ZERO)) else $error("prescaler not cleared");
	AST_CNT_WR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R8
		cnt_wr |=> (cnt_reg == $past(wb_dat_i[7:0]))) else $error("counter write lost");
	AST_CMP_LOAD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R7
		ovf_evt |=> (cmp_reg[0] == $past(duty_reg[0]))) else $error("compare not refreshed");
	AST_CAP_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R19
		capcsr_reg.flag[0] |=> $stable(capv_reg[0])) else $error("capture overwritten");
	AST_CAP_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // R20
		(capcsr_reg.flag[1] && capcsr_reg.ie[1]) |=> cap_irq_o[1])
		else $error("capture irq missing");
	AST_ACK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

endmodule : arpt_timer

/* File: verif/arpt_pins.sv */
/*
 pin-side model: event clock source, capture inputs and a pwm load that times
 the waveform. assumes it shares the timer clock and sees the pins directly.
*/
`timescale 1ns/10ps
module arpt_pins
(
	input  wire logic       clk_i,
	input  wire logic [1:0] pwm_i,
	output logic            evt_o,
	output logic      [1:0] cap_o
);
	initial
	begin
		evt_o = 1'b0;
		cap_o = 2'h0;
	end
	// three cycles per level: the synchroniser loses anything under one
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge clk_i) evt_o <= 1'b1;
			repeat (3) @(posedge clk_i);
			evt_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask : pulses
	task automatic drive_cap(input int ch, input logic lvl);
		@(posedge clk_i) cap_o[ch] <= lvl;
		repeat (6) @(posedge clk_i);
	endtask : drive_cap
	// period and high time in clocks; a zero period means no waveform seen
	task automatic measure(input int ch, output int per, output int hi);
		int st;
		st = 0;
		per = 0;
		hi = 0;
		for (int t = 0; t < 5000 && st < 4; t++)
		begin
			@(posedge clk_i);
			if (pwm_i[ch] === 1'(st % 2))
				st++;
			if (st == 2 || st == 3)
				per++;
			if (st == 2)
				hi++;
		end
		if (st < 4)
			per = 0;
	endtask : measure
endmodule : arpt_pins

/* File: verif/arpt_timer_tb_top.sv */
/*
 self-checking bench of the auto-reload pwm timer: registers, pwm, event
 counting and capture. assumes arpt_pkg and the pin model arpt_pins.
*/
`timescale 1ns/10ps
module arpt_timer_tb_top
	import arpt_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        halt = 1'b0;
	logic        evt;
	logic [1:0]  cap;
	logic [1:0]  pwm;
	logic [1:0]  oe;
	logic        ovf_irq;
	logic [1:0]  cap_irq;
	logic        wake;
	logic [7:0]  v;
	logic [7:0]  v2;
	int          per;
	int          hi;
	int          mismatches = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	arpt_timer i_arpt_timer
	(
		.core_clk_i          (clk),
		.rst_b_i             (rst_b),
		.wb_cyc_i            (cyc),
		.wb_stb_i            (stb),
		.wb_we_i             (we),
		.wb_adr_i            (adr),
		.wb_sel_i            (sel),
		.wb_dat_i            (wdat),
		.wb_dat_o            (rdat),
		.wb_ack_o            (ack),
		.halt_i              (halt),
		.event_clock_input_i (evt),
		.capture_input_pin_i (cap),
		.pwm_out_pin_o       (pwm),
		.pwm_out_pin_oe_o    (oe),
		.ovf_irq_o           (ovf_irq),
		.cap_irq_o           (cap_irq),
		.wake_o              (wake)
	);

	arpt_pins i_arpt_pins
	(
		.clk_i (clk),
		.pwm_i (pwm),
		.evt_o (evt),
		.cap_o (cap)
	);

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int t;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (t >= 20)
		begin
			mismatches++;
			end_of_test();
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		wb(1'b0, a, 8'h00, r);
		chk(32'(r), 32'(e));
	endtask : rdc

	task automatic ones(output int n);
		n = 0;
		repeat (32)
		begin
			@(posedge clk);
			n += int'(pwm[0]);
		end
	endtask : ones

	task automatic t_reg;
		rdc(ARPT_CSR_OFF, 8'h00);
		rdc(ARPT_CNT_OFF, 8'h00);
		chk(32'(oe), 32'h0);
		wr(8'h3C, 8'hFF);
		rdc(8'h3C, 8'h00);
		wr(ARPT_RLD_OFF, 8'hC3);
		@(posedge clk) sel <= 4'hE;
		wr(ARPT_RLD_OFF, 8'h11);
		sel <= 4'hF;
		rdc(ARPT_RLD_OFF, 8'hC3);
		wr(ARPT_CSR_OFF, 8'h04);
		rdc(ARPT_CSR_OFF, 8'h00);
		rdc(ARPT_CNT_OFF, 8'hC3);
		wr(ARPT_CNT_OFF, 8'h5A);
		repeat (20) @(posedge clk);
		rdc(ARPT_CNT_OFF, 8'h5A);
		wr(ARPT_CSR_OFF, 8'h78);
		wr(ARPT_CNT_OFF, 8'h10);
		// ticks land near 128, 256 and 384 cycles; the read sits well clear
		repeat (448) @(posedge clk);
		rdc(ARPT_CNT_OFF, 8'h13);
	endtask : t_reg

	task automatic t_pwm;
		wr(ARPT_RLD_OFF, 8'hF8);
		wr(ARPT_DUTY0_OFF, 8'hFA);
		wr(ARPT_DUTY1_OFF, 8'hFC);
		wr(ARPT_PWMCTL_OFF, 8'h30);
		@(posedge clk);
		chk(32'(oe), 32'h3);
		for (int n = 0; n < 8; n++)
		begin
			wr(ARPT_CSR_OFF, {1'b0, 3'(n), 4'hC});
			i_arpt_pins.measure(0, per, hi);
			chk(per, 8 << n);
			chk(hi, 2 << n);
		end
		i_arpt_pins.measure(1, per, hi);
		chk(hi, 32'd512);
		wr(ARPT_CSR_OFF, 8'h0C);
		wr(ARPT_PWMCTL_OFF, 8'h11);
		i_arpt_pins.measure(0, per, hi);
		chk(hi, 32'd6);
		wr(ARPT_PWMCTL_OFF, 8'h10);
		wr(ARPT_DUTY0_OFF, 8'hFF);
		repeat (20) @(posedge clk);
		ones(hi);
		chk(hi, 32'd0);
		wr(ARPT_DUTY0_OFF, 8'h00);
		repeat (20) @(posedge clk);
		ones(hi);
		chk(hi, 32'd32);
		wr(ARPT_DUTY0_OFF, 8'hFA);
		@(posedge clk) halt <= 1'b1;
		repeat (5) @(posedge clk);
		ones(hi);
		chk(hi % 32, 32'd0);
		@(posedge clk) halt <= 1'b0;
		repeat (4) @(posedge clk);
		wr(ARPT_PWMCTL_OFF, 8'h00);
		ones(hi);
		chk(hi, 32'd0);
	endtask : t_pwm

	task automatic t_evt;
		wr(ARPT_CSR_OFF, 8'h00);
		wb(1'b0, ARPT_CSR_OFF, 8'h00, v);
		wr(ARPT_RLD_OFF, 8'hFD);
		wr(ARPT_CSR_OFF, 8'h8E);
		rdc(ARPT_CSR_OFF, 8'h8A);
		i_arpt_pins.pulses(2);
		repeat (6) @(posedge clk);
		chk(32'(ovf_irq), 32'h0);
		i_arpt_pins.pulses(1);
		repeat (6) @(posedge clk);
		chk(32'(ovf_irq), 32'h1);
		rdc(ARPT_CSR_OFF, 8'h8B);
		rdc(ARPT_CSR_OFF, 8'h8A);
		chk(32'(ovf_irq), 32'h0);
		@(posedge clk) halt <= 1'b1;
		repeat (4) @(posedge clk);
		wr(ARPT_CSR_OFF, 8'h00);
		rdc(ARPT_MODE_OFF, 8'h01);
		i_arpt_pins.pulses(3);
		repeat (6) @(posedge clk);
		chk(32'(wake), 32'h1);
		@(posedge clk) halt <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(ARPT_CSR_OFF, 8'h8B);
	endtask : t_evt

	task automatic t_cap;
		wr(ARPT_CSR_OFF, 8'h08);
		wr(ARPT_CAPCSR_OFF, 8'h1C);
		rdc(ARPT_CAPCSR_OFF, 8'h1C);
		i_arpt_pins.drive_cap(1, 1'b1);
		chk(32'(cap_irq), 32'h0);
		i_arpt_pins.drive_cap(0, 1'b1);
		chk(32'(cap_irq), 32'h1);
		wb(1'b0, ARPT_CAPV0_OFF, 8'h00, v);
		i_arpt_pins.drive_cap(0, 1'b0);
		i_arpt_pins.drive_cap(0, 1'b1);
		wb(1'b0, ARPT_CAPV0_OFF, 8'h00, v2);
		chk(32'(v2), 32'(v));
		rdc(ARPT_CAPCSR_OFF, 8'h1D);
		rdc(ARPT_CAPCSR_OFF, 8'h1C);
		chk(32'(cap_irq), 32'h0);
		i_arpt_pins.drive_cap(1, 1'b0);
		chk(32'(cap_irq), 32'h2);
		rdc(ARPT_CAPCSR_OFF, 8'h1E);
		@(posedge clk) halt <= 1'b1;
		repeat (4) @(posedge clk);
		i_arpt_pins.drive_cap(0, 1'b0);
		i_arpt_pins.drive_cap(0, 1'b1);
		chk(32'(wake), 32'h1);
		@(posedge clk) halt <= 1'b0;
		repeat (4) @(posedge clk);
		wb(1'b0, ARPT_CAPV0_OFF, 8'h00, v2);
		chk(32'(v2), 32'(v));
	endtask : t_cap

	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_reg();
		t_pwm();
		t_evt();
		t_cap();
		end_of_test();
	end
endmodule : arpt_timer_tb_top
